/* hdl/tcq_pkg.sv */
// constants and types for the trace clock qualifier
// Function
// - five clock sources: two probe inputs, bus clock, mode clock, spare; all but the spare are selectable.
// - the emulator generates the bus-timing clock from processor bus activity.
// - the emulator generates the mode clock, used for clocking and for user/background qualification.
// - the spare clock is generated but never clocks or qualifies an analyzer.
// - bus-timing and mode clocks serve both analyzers, for clocking and qualifying.
// - probe clocks come from the external trace probe clock inputs.
// - probe clocks never master the emulation trace, only qualify it.
// - rising-edge option samples once on each low-to-high transition.
// - falling-edge option samples once on each high-to-low transition.
// - either-edge option samples on both transitions.
// - low-level qualifier accepts edges only while that clock is low.
// - high-level qualifier accepts edges only while that clock is high.
// - background qualifier clocks only while the background monitor runs.
// - user qualifier clocks only while user code runs; it is the default.
// - emulation analyzer defaults to rising edge on the bus-timing clock.
// - run-state qualifiers are ORed with all other qualifiers.
// - a speed class is selectable: slow, fast or very fast.
package tcq_pkg;

  localparam int CLK_N = 5;

  // clock source indices
  localparam logic [2:0] SRC_PROBE_A = 3'h0;
  localparam logic [2:0] SRC_PROBE_B = 3'h1;
  localparam logic [2:0] SRC_BUS = 3'h2;
  localparam logic [2:0] SRC_MODE = 3'h3;
  localparam logic [2:0] SRC_SPARE = 3'h4;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } tcq_edge_t;

  typedef enum logic [1:0] {
    SPD_SLOW = 2'b00,
    SPD_FAST = 2'b01,
    SPD_VFAST = 2'b10,
    SPD_BAD = 2'b11
  } tcq_speed_t;

  typedef struct packed {
    logic run;
    tcq_speed_t speed;
    logic user;
    logic bg;
    logic [4:0] hi;
    logic [4:0] lo;
    tcq_edge_t edge_mode;
    logic [2:0] sel;
  } tcq_cfg_t;

  // register byte offsets
  localparam logic [7:0] OFS_EMU_CFG = 8'h00;
  localparam logic [7:0] OFS_EXT_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_EMU_CNT = 8'h0C;
  localparam logic [7:0] OFS_EXT_CNT = 8'h10;

  // configuration field positions
  localparam int SEL_LSB = 0;
  localparam int EDGE_LSB = 4;
  localparam int LO_LSB = 8;
  localparam int HI_LSB = 16;
  localparam int BG_BIT = 24;
  localparam int USER_BIT = 25;
  localparam int SPD_LSB = 28;
  localparam int RUN_BIT = 31;

  // status field positions
  localparam int ST_LVL_LSB = 0;
  localparam int ST_EMU_TIME = 8;
  localparam int ST_EMU_STATE = 9;
  localparam int ST_EXT_TIME = 10;
  localparam int ST_EXT_STATE = 11;

  // reset values
  localparam logic [31:0] EMU_CFG_RST = 32'h82000012;
  localparam logic [31:0] EXT_CFG_RST = 32'h82000010;

endpackage

/* hdl/tcq_edge_if.sv */
// clock levels and edges handed from the synchroniser to the qualifier
`timescale 1ns/1ns
interface tcq_edge_if #(
  parameter int W = 5
);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

/* hdl/tcq_edge_sync.sv */
// two-stage synchroniser and edge detector for the clock sources
`timescale 1ns/1ns
module tcq_edge_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw source levels
  input wire logic [W-1:0] raw,
  // levels and edges, aligned
  tcq_edge_if.src eo
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] rise_q;
  logic [W-1:0] fall_q;

  initial
  begin
    if (W < 1)
      $error("edge sync width must be at least one");
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level is registered with the edge so qualifiers see the same instant
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      lvl_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end
    else
    begin
      lvl_q <= s3_q;
      rise_q <= s2_q & ~s3_q;
      fall_q <= ~s2_q & s3_q;
    end
  end

  assign eo.lvl = lvl_q;
  assign eo.rise = rise_q;
  assign eo.fall = fall_q;

endmodule

/* hdl/tcq_trace_clock_qualifier.sv */
// master clock edge selection and qualification for both trace analyzers
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module tcq_trace_clock_qualifier
  import tcq_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,

  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,

  // external trace probe clock pins
  input wire logic probe_input_a,
  input wire logic probe_input_b,

  // emulation processor state pins
  input wire logic bus_cycle_strobe,
  input wire logic monitor_active,

  // generated clocks routed to the external analyzer
  output logic emu_bus_timing,
  output logic mode_qualifier_tap,
  output logic spare_clock,

  // qualified sample strobes
  output logic emu_sample,
  output logic ext_sample,

  // speed class per analyzer
  output logic [1:0] emu_speed,
  output logic [1:0] ext_speed
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------

  initial
  begin
    if (ADDR_W < 8)
      $error("address width too small for the register map");
    if (CNT_W < 1 || CNT_W > 32)
      $error("counter width must be 1 to 32");
  end

  // ------------------------------------------------------------
  // clock sources
  // ------------------------------------------------------------

  logic [CLK_N-1:0] src_raw;
  logic spare_q;

  // spare is held low so it can never produce an edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      spare_q <= 1'b0;
    else
      spare_q <= 1'b0;
  end

  always_comb
  begin
    src_raw = '0;
    src_raw[SRC_PROBE_A] = probe_input_a;
    src_raw[SRC_PROBE_B] = probe_input_b;
    src_raw[SRC_BUS] = bus_cycle_strobe;
    src_raw[SRC_MODE] = monitor_active;
    src_raw[SRC_SPARE] = spare_q;
  end

  tcq_edge_if #(.W(CLK_N)) ev ();

  tcq_edge_sync #(
    .W(CLK_N)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw(src_raw),
    .eo(ev)
  );

  // all three generated clocks also leave the block for the external side
  assign emu_bus_timing = ev.lvl[SRC_BUS];
  assign mode_qualifier_tap = ev.lvl[SRC_MODE];
  assign spare_clock = spare_q;

  // ------------------------------------------------------------
  // configuration helpers
  // ------------------------------------------------------------

  function automatic tcq_cfg_t unpack_cfg(input logic [31:0] w);
    tcq_cfg_t c;
    c.sel = w[SEL_LSB +: 3];
    c.edge_mode = tcq_edge_t'(w[EDGE_LSB +: 2]);
    c.lo = w[LO_LSB +: 5];
    c.hi = w[HI_LSB +: 5];
    c.bg = w[BG_BIT];
    c.user = w[USER_BIT];
    c.speed = tcq_speed_t'(w[SPD_LSB +: 2]);
    c.run = w[RUN_BIT];
    return c;
  endfunction

  function automatic logic [31:0] pack_cfg(input tcq_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[SEL_LSB +: 3] = c.sel;
    w[EDGE_LSB +: 2] = c.edge_mode;
    w[LO_LSB +: 5] = c.lo;
    w[HI_LSB +: 5] = c.hi;
    w[BG_BIT] = c.bg;
    w[USER_BIT] = c.user;
    w[SPD_LSB +: 2] = c.speed;
    w[RUN_BIT] = c.run;
    return w;
  endfunction

  // a refused write leaves the old setting in place
  function automatic logic cfg_ok(input logic is_emu, input tcq_cfg_t c);
    logic ok;
    ok = (c.sel < SRC_SPARE);
    if (is_emu && (c.sel == SRC_PROBE_A || c.sel == SRC_PROBE_B))
      ok = 1'b0;
    if (c.edge_mode == EDGE_NONE)
      ok = 1'b0;
    if (c.speed == SPD_BAD)
      ok = 1'b0;
    if (c.lo[SRC_SPARE] || c.hi[SRC_SPARE])
      ok = 1'b0;
    return ok;
  endfunction

  // ------------------------------------------------------------
  // edge qualification
  // ------------------------------------------------------------

  function automatic logic sample_hit(
    input tcq_cfg_t c,
    input logic [CLK_N-1:0] lv,
    input logic [CLK_N-1:0] rs,
    input logic [CLK_N-1:0] fl
  );
    logic edge_ok;
    logic q_on;
    logic q_any;
    logic bgnd;
    bgnd = lv[SRC_MODE];
    edge_ok = 1'b0;
    case (c.edge_mode)
      EDGE_RISE: edge_ok = rs[c.sel];
      EDGE_FALL: edge_ok = fl[c.sel];
      EDGE_BOTH: edge_ok = rs[c.sel] | fl[c.sel];
      default: edge_ok = 1'b0;
    endcase
    q_on = (|c.lo) | (|c.hi) | c.bg | c.user;
    q_any = |(c.lo & ~lv);
    q_any = q_any | (|(c.hi & lv));
    q_any = q_any | (c.bg & bgnd);
    q_any = q_any | (c.user & ~bgnd);
    // no qualifier at all means every selected edge counts
    return c.run & edge_ok & (~q_on | q_any);
  endfunction

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------

  logic [7:0] ofs;
  logic hit_emu_cfg;
  logic hit_ext_cfg;
  logic hit_status;
  logic hit_emu_cnt;
  logic hit_ext_cnt;
  logic hit_any;
  logic wr_acc;
  logic bad_wr;
  tcq_cfg_t wcfg;

  assign ofs = paddr[7:0];
  assign wcfg = unpack_cfg(pwdata);
  assign wr_acc = psel & penable & pwrite;

  always_comb
  begin
    hit_emu_cfg = 1'b0;
    hit_ext_cfg = 1'b0;
    hit_status = 1'b0;
    hit_emu_cnt = 1'b0;
    hit_ext_cnt = 1'b0;
    if (ofs == OFS_EMU_CFG)
      hit_emu_cfg = 1'b1;
    else if (ofs == OFS_EXT_CFG)
      hit_ext_cfg = 1'b1;
    else if (ofs == OFS_STATUS)
      hit_status = 1'b1;
    else if (ofs == OFS_EMU_CNT)
      hit_emu_cnt = 1'b1;
    else if (ofs == OFS_EXT_CNT)
      hit_ext_cnt = 1'b1;
  end

  assign hit_any = hit_emu_cfg | hit_ext_cfg | hit_status | hit_emu_cnt | hit_ext_cnt;

  always_comb
  begin
    bad_wr = 1'b0;
    if (hit_emu_cfg)
      bad_wr = ~cfg_ok(1'b1, wcfg);
    else if (hit_ext_cfg)
      bad_wr = ~cfg_ok(1'b0, wcfg);
    else if (hit_status)
      bad_wr = 1'b1;
  end

  // zero wait states; read data was captured in the setup cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & (~hit_any | (pwrite & bad_wr));

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------

  tcq_cfg_t emu_cfg_q;
  tcq_cfg_t ext_cfg_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      emu_cfg_q <= unpack_cfg(EMU_CFG_RST);
    else if (wr_acc && hit_emu_cfg && cfg_ok(1'b1, wcfg))
      emu_cfg_q <= wcfg;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ext_cfg_q <= unpack_cfg(EXT_CFG_RST);
    else if (wr_acc && hit_ext_cfg && cfg_ok(1'b0, wcfg))
      ext_cfg_q <= wcfg;
  end

  assign emu_speed = emu_cfg_q.speed;
  assign ext_speed = ext_cfg_q.speed;

  // ------------------------------------------------------------
  // sample strobes
  // ------------------------------------------------------------

  logic emu_sample_q;
  logic ext_sample_q;
  logic emu_hit;
  logic ext_hit;

  assign emu_hit = sample_hit(emu_cfg_q, ev.lvl, ev.rise, ev.fall);
  assign ext_hit = sample_hit(ext_cfg_q, ev.lvl, ev.rise, ev.fall);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      emu_sample_q <= 1'b0;
      ext_sample_q <= 1'b0;
    end
    else
    begin
      emu_sample_q <= emu_hit;
      ext_sample_q <= ext_hit;
    end
  end

  assign emu_sample = emu_sample_q;
  assign ext_sample = ext_sample_q;

  // ------------------------------------------------------------
  // sample counters
  // ------------------------------------------------------------

  logic [CNT_W-1:0] emu_cnt_q;
  logic [CNT_W-1:0] ext_cnt_q;
  logic emu_clr;
  logic ext_clr;

  assign emu_clr = wr_acc & hit_emu_cnt;
  assign ext_clr = wr_acc & hit_ext_cnt;

  // a sample landing on the clear is kept: count restarts at one
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      emu_cnt_q <= '0;
    else if (emu_clr)
      emu_cnt_q <= CNT_W'(emu_sample_q);
    else if (emu_sample_q)
      emu_cnt_q <= emu_cnt_q + 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ext_cnt_q <= '0;
    else if (ext_clr)
      ext_cnt_q <= CNT_W'(ext_sample_q);
    else if (ext_sample_q)
      ext_cnt_q <= ext_cnt_q + 1'b1;
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------

  logic [31:0] status_w;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;

  always_comb
  begin
    status_w = '0;
    status_w[ST_LVL_LSB +: CLK_N] = ev.lvl;
    status_w[ST_EMU_TIME] = (emu_cfg_q.speed == SPD_SLOW);
    status_w[ST_EMU_STATE] = (emu_cfg_q.speed != SPD_VFAST);
    status_w[ST_EXT_TIME] = (ext_cfg_q.speed == SPD_SLOW);
    status_w[ST_EXT_STATE] = (ext_cfg_q.speed != SPD_VFAST);
  end

  always_comb
  begin
    rd_d = '0;
    if (hit_emu_cfg)
      rd_d = pack_cfg(emu_cfg_q);
    else if (hit_ext_cfg)
      rd_d = pack_cfg(ext_cfg_q);
    else if (hit_status)
      rd_d = status_w;
    else if (hit_emu_cnt)
      rd_d = 32'(emu_cnt_q);
    else if (hit_ext_cnt)
      rd_d = 32'(ext_cnt_q);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prdata_q <= '0;
    else if (psel && !penable && !pwrite)
      prdata_q <= rd_d;
  end

  assign prdata = prdata_q;

endmodule

/* sim/tcq_trace_clock_qualifier_properties.sv */
// port-level checks on the trace clock qualifier
`timescale 1ns/1ns
module tcq_checker
  import tcq_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic probe_input_a,
  input wire logic probe_input_b,
  input wire logic bus_cycle_strobe,
  input wire logic monitor_active,
  // outputs
  input wire logic emu_bus_timing,
  input wire logic mode_qualifier_tap,
  input wire logic spare_clock,
  input wire logic emu_sample,
  input wire logic ext_sample,
  input wire logic [1:0] emu_speed,
  input wire logic [1:0] ext_speed
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_ready;
    pready == (psel && penable);
  endproperty
  a_ready: assert property (p_ready) else $error("pready not equal to access phase");
  property p_spare;
    !spare_clock && !emu_sample || !spare_clock;
  endproperty
  a_spare: assert property (p_spare) else $error("spare clock moved");
  property p_emu_pulse;
    emu_sample |=> !emu_sample;
  endproperty
  a_emu_pulse: assert property (p_emu_pulse) else $error("emu sample longer than one cycle");
  property p_ext_pulse;
    ext_sample |=> !ext_sample;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse) else $error("ext sample longer than one cycle");
  property p_bus_rise;
    $rose(bus_cycle_strobe) ##1 bus_cycle_strobe [*4] |-> ##[0:4] emu_bus_timing;
  endproperty
  a_bus_rise: assert property (p_bus_rise) else $error("bus timing clock missed a rise");
  property p_bus_fall;
    $fell(bus_cycle_strobe) ##1 !bus_cycle_strobe [*4] |-> ##[0:4] !emu_bus_timing;
  endproperty
  a_bus_fall: assert property (p_bus_fall) else $error("bus timing clock missed a fall");
  property p_mode_rise;
    $rose(monitor_active) ##1 monitor_active [*4] |-> ##[0:4] mode_qualifier_tap;
  endproperty
  a_mode_rise: assert property (p_mode_rise) else $error("mode clock missed a rise");
  property p_unmapped;
    psel && penable && (paddr > OFS_EXT_CNT || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_speed;
    emu_speed != 2'h3 && ext_speed != 2'h3;
  endproperty
  a_speed: assert property (p_speed) else $error("illegal speed class shown");
  c_emu: cover property (emu_sample);
  c_ext: cover property (ext_sample);
  c_err: cover property (pready && pslverr);
endmodule

bind tcq_trace_clock_qualifier tcq_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_tcq_checker (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .probe_input_a(probe_input_a),
  .probe_input_b(probe_input_b), .bus_cycle_strobe(bus_cycle_strobe), .monitor_active(monitor_active),
  .emu_bus_timing(emu_bus_timing), .mode_qualifier_tap(mode_qualifier_tap), .spare_clock(spare_clock),
  .emu_sample(emu_sample), .ext_sample(ext_sample), .emu_speed(emu_speed), .ext_speed(ext_speed)
);

/* sim/tcq_target_model.sv */
// target bus and probe pins: 0 probe a, 1 probe b, 2 bus strobe, 3 monitor
`timescale 1ns/1ns
module tcq_target_model (
  // clock
  input wire logic clk_sys,
  // pins
  output logic probe_input_a,
  output logic probe_input_b,
  output logic bus_cycle_strobe,
  output logic monitor_active
);
  logic [3:0] pins_q;
  assign {monitor_active, bus_cycle_strobe, probe_input_b, probe_input_a} = pins_q;
  initial pins_q = 4'h0;
  // slow pulses: well under the 5 MHz the synchroniser can follow
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      pins_q[idx] <= 1'b1;
      repeat (5) @(posedge clk_sys);
      pins_q[idx] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task automatic set_lvl(input int idx, input logic v);
    @(posedge clk_sys);
    pins_q[idx] <= v;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

/* sim/trace_clock_qualifier_bench.sv */
// self-checking bench for the trace clock qualifier
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module trace_clock_qualifier_bench
  import tcq_pkg::*;
;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pa, pb, bus, mon, ebt, mqt, spr, es, xs;
  logic [1:0] esp, xsp;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;

  tcq_trace_clock_qualifier #(.ADDR_W(8), .CNT_W(16)) i_tcq_trace_clock_qualifier (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .probe_input_a(pa),
    .probe_input_b(pb), .bus_cycle_strobe(bus), .monitor_active(mon), .emu_bus_timing(ebt),
    .mode_qualifier_tap(mqt), .spare_clock(spr), .emu_sample(es), .ext_sample(xs),
    .emu_speed(esp), .ext_speed(xsp)
  );
  tcq_target_model i_tcq_target_model (
    .clk_sys(clk_sys), .probe_input_a(pa), .probe_input_b(pb), .bus_cycle_strobe(bus), .monitor_active(mon)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------
  // bus and helper tasks
  // --------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `CHK(e, ee)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, ex)
    `CHK(e, ee)
  endtask
  // clear a counter, drive n pulses on pin p, read the count back
  task automatic cnt(input logic [7:0] a, input int p, input int n, input logic [31:0] ex);
    wr(a, 32'h0, 1'b0);
    i_tcq_target_model.pulse(p, n);
    repeat (8) @(posedge clk_sys);
    rd(a, ex, 1'b0);
  endtask
  function automatic logic [31:0] cfg(logic [2:0] s, logic [1:0] ed, logic [4:0] lo, logic [4:0] hi, logic bg,
                                      logic us);
    cfg = 32'h80000000 | (32'(s) << SEL_LSB) | (32'(ed) << EDGE_LSB) | (32'(lo) << LO_LSB)
          | (32'(hi) << HI_LSB) | (32'(bg) << BG_BIT) | (32'(us) << USER_BIT);
  endfunction

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_regs();
    rd(OFS_EMU_CFG, EMU_CFG_RST, 1'b0);
    rd(OFS_EXT_CFG, EXT_CFG_RST, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(OFS_STATUS, 32'hFFFFFFFF, 1'b1);
  endtask
  task automatic t_edges();
    for (int e = 1; e < 4; e++)
    begin
      wr(OFS_EMU_CFG, cfg(SRC_BUS, 2'(e), 5'h00, 5'h00, 1'b0, 1'b1), 1'b0);
      cnt(OFS_EMU_CNT, 2, 3, (e == 3) ? 32'h6 : 32'h3);
    end
  endtask
  task automatic t_runstate();
    wr(OFS_EMU_CFG, cfg(SRC_BUS, 2'h1, 5'h00, 5'h00, 1'b1, 1'b0), 1'b0);
    i_tcq_target_model.set_lvl(3, 1'b1);
    cnt(OFS_EMU_CNT, 2, 3, 32'h3);
    wr(OFS_EMU_CFG, EMU_CFG_RST, 1'b0);
    cnt(OFS_EMU_CNT, 2, 3, 32'h0);
    i_tcq_target_model.set_lvl(3, 1'b0);
    cnt(OFS_EMU_CNT, 2, 3, 32'h3);
    // run-state false but a probe level true still clocks
    wr(OFS_EMU_CFG, cfg(SRC_BUS, 2'h1, 5'h00, 5'h02, 1'b1, 1'b0), 1'b0);
    i_tcq_target_model.set_lvl(1, 1'b1);
    cnt(OFS_EMU_CNT, 2, 3, 32'h3);
    i_tcq_target_model.set_lvl(1, 1'b0);
    cnt(OFS_EMU_CNT, 2, 3, 32'h0);
  endtask
  task automatic t_refuse();
    logic [31:0] keep;
    keep = cfg(SRC_BUS, 2'h1, 5'h00, 5'h02, 1'b1, 1'b0);
    wr(OFS_EMU_CFG, cfg(SRC_PROBE_A, 2'h1, 5'h00, 5'h00, 1'b0, 1'b1), 1'b1);
    wr(OFS_EMU_CFG, cfg(SRC_SPARE, 2'h1, 5'h00, 5'h00, 1'b0, 1'b1), 1'b1);
    wr(OFS_EXT_CFG, cfg(SRC_SPARE, 2'h1, 5'h00, 5'h00, 1'b0, 1'b1), 1'b1);
    rd(OFS_EMU_CFG, keep, 1'b0);
    wr(OFS_EMU_CFG, EMU_CFG_RST | 32'h20000000, 1'b0);
    // speed output follows the register written on the write edge, so check one edge later
    @(posedge clk_sys);
    `CHK(esp, 2'h2)
    wr(OFS_EMU_CFG, EMU_CFG_RST | 32'h30000000, 1'b1);
  endtask
  task automatic t_ext();
    cnt(OFS_EXT_CNT, 0, 3, 32'h3);
    wr(OFS_EXT_CFG, cfg(SRC_BUS, 2'h1, 5'h00, 5'h00, 1'b0, 1'b1), 1'b0);
    cnt(OFS_EXT_CNT, 2, 3, 32'h3);
    wr(OFS_EXT_CFG, cfg(SRC_MODE, 2'h1, 5'h00, 5'h00, 1'b0, 1'b0), 1'b0);
    cnt(OFS_EXT_CNT, 3, 3, 32'h3);
    wr(OFS_EXT_CFG, cfg(SRC_PROBE_A, 2'h1, 5'h02, 5'h00, 1'b0, 1'b0), 1'b0);
    cnt(OFS_EXT_CNT, 0, 3, 32'h3);
    i_tcq_target_model.set_lvl(1, 1'b1);
    rd(OFS_STATUS, 32'h00000C02, 1'b0);
    cnt(OFS_EXT_CNT, 0, 3, 32'h0);
    wr(OFS_EXT_CFG, cfg(SRC_PROBE_B, 2'h2, 5'h00, 5'h01, 1'b0, 1'b0), 1'b0);
    cnt(OFS_EXT_CNT, 1, 2, 32'h0);
    wr(OFS_EXT_CFG, EXT_CFG_RST | 32'h10000000, 1'b0);
    @(posedge clk_sys);
    `CHK(xsp, 2'h1)
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard: the scenarios need under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_edges();
    t_runstate();
    t_refuse();
    t_ext();
    report_and_stop();
  end
endmodule
